// ===== wdtu_map.svh
// Constants for the watchdog time-out unit: bit positions, ratios, timing.
// Assumes inclusion by the watchdog files only; definitions, no logic.
`ifndef WDTU_MAP_SVH
`define WDTU_MAP_SVH

// ****************************************************************
// Configuration word fields
// ****************************************************************
`define WDTU_CFG_POST_LSB 0
`define WDTU_CFG_POST_MSB 3
`define WDTU_CFG_PRE_BIT 4
`define WDTU_CFG_WINDOW_DISABLE_BIT 6
`define WDTU_CFG_FUSE_EN_BIT 7

// ****************************************************************
// Reset-control register bit positions
// ****************************************************************
`define WDTU_RCR_IDLE_BIT 2
`define WDTU_RCR_SLEEP_BIT 3
`define WDTU_RCR_TO_BIT 4
`define WDTU_RCR_SWEN_BIT 5

// ****************************************************************
// Prescaler ratios and timing
// ****************************************************************
`define WDTU_PRE_DIV_SMALL 8'd32
`define WDTU_PRE_DIV_LARGE 8'd128
`define WDTU_LOW_POWER_RC_OSC_KHZ 32
`define WDTU_BASE_MS_SMALL 1
`define WDTU_BASE_MS_LARGE 4
`define WDTU_POST_WIDTH 16

`endif

// ===== wdtu_pkg.sv
// Types shared by the watchdog time-out unit files.
// Assumes wdtu_map.svh is compiled alongside.
package wdtu_pkg;
  // Power state as seen by the watchdog
  typedef enum logic [1:0] {
    WDTU_RUN = 2'b00,
    WDTU_SLEEP = 2'b01,
    WDTU_IDLE = 2'b10
  } wdtu_pwr_type;
endpackage : wdtu_pkg

// ===== wdtu_prescaler.sv
// Prescaler: divides oscillator ticks by 32 or 128.
// Assumes osc_tick is a one-cycle enable at the oscillator rate.
`timescale 1ns/1ps
`default_nettype none
`include "wdtu_map.svh"
module wdtu_prescaler (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic clr,
  input wire logic run,
  input wire logic osc_tick,
  input wire logic div_large,
  // Output enable pulse
  output logic pre_tick
);
  import wdtu_pkg::*;

  // ****************************************************************
  // Divider
  // ****************************************************************
  logic [7:0] cnt_ff; // Ticks seen so far
  logic [7:0] nxt_cnt;
  logic [7:0] limit; // Terminal count
  logic nxt_tick;
  logic tick_ff;

  // Next-state: count oscillator ticks, wrap at limit
  always_comb begin
    limit = div_large ? `WDTU_PRE_DIV_LARGE : `WDTU_PRE_DIV_SMALL;
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (clr) begin
      nxt_cnt = 8'h00;
    end else if (run && osc_tick) begin
      if (cnt_ff == limit - 8'h01) begin
        nxt_cnt = 8'h00;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign pre_tick = tick_ff;
endmodule : wdtu_prescaler
`default_nettype wire

// ===== wdtu_postscaler.sv
// Postscaler: counts prescaler pulses up to 2**sel, flags window.
// Assumes pre_tick is one cycle wide.
`timescale 1ns/1ps
`default_nettype none
`include "wdtu_map.svh"
module wdtu_postscaler (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic clr,
  input wire logic pre_tick,
  input wire logic [3:0] post_sel,
  // Status
  output logic expire,
  output logic in_window
);
  import wdtu_pkg::*;

  // ****************************************************************
  // Counter
  // ****************************************************************
  logic [15:0] cnt_ff; // Prescaler periods elapsed
  logic [15:0] nxt_cnt;
  logic [16:0] ratio; // 1 to 32768
  logic [16:0] cnt_ext;
  logic nxt_expire;
  logic expire_ff;

  // Next-state: expire on the last prescaler period of the ratio
  always_comb begin
    ratio = 17'h00001 << post_sel;
    cnt_ext = {1'b0, cnt_ff};
    nxt_cnt = cnt_ff;
    nxt_expire = 1'b0;
    if (clr) begin
      nxt_cnt = 16'h0000;
    end else if (pre_tick) begin
      if (cnt_ext + 17'h00001 >= ratio) begin
        nxt_cnt = 16'h0000;
        nxt_expire = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
      expire_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      expire_ff <= nxt_expire;
    end
  end

  // Last quarter: elapsed*4 >= 3*ratio. With ratio 1 or 2 the count never
  // reaches three quarters of the period, so the window never opens and
  // every windowed clear is judged early (limitation).
  assign in_window = ({cnt_ext, 2'b00} >= ({2'b00, ratio} * 19'h00003));
  assign expire = expire_ff;
endmodule : wdtu_postscaler
`default_nettype wire

// ===== wdtu_top.sv
// Watchdog time-out unit top: enables, clear sources, wake and reset.
// Assumes all inputs synchronous to clk_sys; osc_tick is a one-cycle
// enable at the low-power oscillator rate produced elsewhere.
`timescale 1ns/1ps
`default_nettype none
`include "wdtu_map.svh"
module wdtu_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Configuration word and oscillator
  input wire logic [7:0] watchdog_config_word,
  input wire logic osc_tick,
  // Core events, one-cycle pulses
  input wire logic watchdog_clear_instr,
  input wire logic power_save_instr,
  input wire logic power_save_idle,
  input wire logic power_save_exit,
  input wire logic clock_switch_done,
  // Software writes to reset-control bits
  input wire logic soft_enable_set,
  input wire logic soft_enable_clr,
  input wire logic timeout_flag_clr,
  input wire logic sleep_flag_clr,
  input wire logic idle_flag_clr,
  // Outputs
  output logic low_power_rc_osc_en,
  output logic watchdog_reset,
  output logic wake_request,
  output logic [7:0] reset_control_reg
);
  import wdtu_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wdtu_pwr_type pwr_ff, nxt_pwr; // Current power state
  logic swen_ff, nxt_swen; // Software enable
  logic to_ff, nxt_to; // Time-out flag
  logic slp_ff, nxt_slp; // Sleep status flag
  logic idl_ff, nxt_idl; // Idle status flag
  logic rst_ff, nxt_rst; // Watchdog reset pulse
  logic wake_ff, nxt_wake; // Wake pulse
  logic osc_en_ff, nxt_osc_en;
  logic enabled; // Watchdog running
  logic clr_all; // Clears prescaler and postscaler
  logic pre_tick;
  logic expire;
  logic in_window;
  logic early_clr; // Clear outside the window
  logic fuse_en;
  logic window_disable;

  assign fuse_en = watchdog_config_word[`WDTU_CFG_FUSE_EN_BIT];
  assign window_disable = watchdog_config_word[`WDTU_CFG_WINDOW_DISABLE_BIT];
  assign enabled = fuse_en | swen_ff;

  // Clear sources. Clear instruction only counts while running normally;
  // a watchdog reset also clears since it is a device reset.
  always_comb begin
    clr_all = 1'b0;
    if (clock_switch_done) begin
      clr_all = 1'b1;
    end
    if (power_save_instr || power_save_exit) begin
      clr_all = 1'b1;
    end
    if (watchdog_clear_instr && pwr_ff == WDTU_RUN) begin
      clr_all = 1'b1;
    end
    if (rst_ff || !enabled) begin
      clr_all = 1'b1;
    end
  end

  assign early_clr = watchdog_clear_instr && (pwr_ff == WDTU_RUN) &&
                     enabled && !window_disable && !in_window;

  // ****************************************************************
  // Counter chain
  // ****************************************************************
  wdtu_prescaler u_pre (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(clr_all),
    .run(enabled),
    .osc_tick(osc_tick),
    .div_large(watchdog_config_word[`WDTU_CFG_PRE_BIT]),
    .pre_tick(pre_tick)
  );

  wdtu_postscaler u_post (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(clr_all),
    .pre_tick(pre_tick),
    .post_sel(watchdog_config_word[`WDTU_CFG_POST_MSB:`WDTU_CFG_POST_LSB]),
    .expire(expire),
    .in_window(in_window)
  );

  // ****************************************************************
  // Status and event logic
  // ****************************************************************
  // Next values: flags set wins over software clear
  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_swen = swen_ff;
    nxt_to = to_ff;
    nxt_slp = slp_ff;
    nxt_idl = idl_ff;
    nxt_rst = 1'b0;
    nxt_wake = 1'b0;
    nxt_osc_en = enabled;
    // Software enable bit
    if (soft_enable_set) begin
      nxt_swen = 1'b1;
    end else if (soft_enable_clr) begin
      nxt_swen = 1'b0;
    end
    // Status flags cleared by software after wake-up
    if (sleep_flag_clr) begin
      nxt_slp = 1'b0;
    end
    if (idle_flag_clr) begin
      nxt_idl = 1'b0;
    end
    if (timeout_flag_clr) begin
      nxt_to = 1'b0;
    end
    // Power state tracking
    if (power_save_instr && pwr_ff == WDTU_RUN) begin
      nxt_pwr = power_save_idle ? WDTU_IDLE : WDTU_SLEEP;
      if (power_save_idle) begin
        nxt_idl = 1'b1;
      end else begin
        nxt_slp = 1'b1;
      end
    end else if (power_save_exit) begin
      nxt_pwr = WDTU_RUN;
    end
    // Time-out handling
    if (expire && enabled && !rst_ff) begin
      nxt_to = 1'b1;
      if (pwr_ff != WDTU_RUN) begin
        nxt_wake = 1'b1;
        nxt_pwr = WDTU_RUN;
      end else begin
        nxt_rst = 1'b1;
      end
    end
    if (early_clr && !rst_ff) begin
      nxt_rst = 1'b1;
    end
    // A watchdog reset is a device reset: software enable drops
    if (rst_ff) begin
      nxt_swen = 1'b0;
      nxt_pwr = WDTU_RUN;
    end
  end

  // Register stage; async reset clears everything
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff <= WDTU_RUN;
      swen_ff <= 1'b0;
      to_ff <= 1'b0;
      slp_ff <= 1'b0;
      idl_ff <= 1'b0;
      rst_ff <= 1'b0;
      wake_ff <= 1'b0;
      osc_en_ff <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      swen_ff <= nxt_swen;
      to_ff <= nxt_to;
      slp_ff <= nxt_slp;
      idl_ff <= nxt_idl;
      rst_ff <= nxt_rst;
      wake_ff <= nxt_wake;
      osc_en_ff <= nxt_osc_en;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign low_power_rc_osc_en = osc_en_ff;
  assign watchdog_reset = rst_ff;
  assign wake_request = wake_ff;

  // Reset-control view: bits 2..5, others read zero
  always_comb begin
    reset_control_reg = 8'h00;
    reset_control_reg[`WDTU_RCR_IDLE_BIT] = idl_ff;
    reset_control_reg[`WDTU_RCR_SLEEP_BIT] = slp_ff;
    reset_control_reg[`WDTU_RCR_TO_BIT] = to_ff;
    reset_control_reg[`WDTU_RCR_SWEN_BIT] = swen_ff;
  end
endmodule : wdtu_top
`default_nettype wire

// ===== wdtu_props.sv
// Concurrent checks on the ports of the watchdog time-out unit.
// Assumes binding to wdtu_top; every signal is in the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
`include "wdtu_map.svh"
module wdtu_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Inputs watched
  input wire logic [7:0] watchdog_config_word,
  input wire logic power_save_instr,
  input wire logic soft_enable_set,
  input wire logic timeout_flag_clr,
  input wire logic sleep_flag_clr,
  input wire logic idle_flag_clr,
  // Outputs watched
  input wire logic low_power_rc_osc_en,
  input wire logic watchdog_reset,
  input wire logic wake_request,
  input wire logic [7:0] reset_control_reg
);
  import wdtu_pkg::*;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Either enable source is active
  logic en;
  assign en = watchdog_config_word[`WDTU_CFG_FUSE_EN_BIT] |
              reset_control_reg[`WDTU_RCR_SWEN_BIT];
  osc_on_a: assert property (en |=> low_power_rc_osc_en)
    else $error("oscillator not enabled");
  osc_off_a: assert property (!en |=> !low_power_rc_osc_en)
    else $error("oscillator on while disabled");
  // Pipeline may still hold a count, so wait three idle cycles
  quiet_off_a: assert property (
    (!en) [*3] |-> !watchdog_reset && !wake_request)
    else $error("event while disabled");
  rst_pulse_a: assert property (
    watchdog_reset |=> !watchdog_reset)
    else $error("reset pulse too long");
  wake_pulse_a: assert property (
    wake_request |=> !wake_request)
    else $error("wake pulse too long");
  wake_excl_a: assert property (
    !(wake_request && watchdog_reset))
    else $error("wake and reset together");
  flag_cause_a: assert property (
    $rose(reset_control_reg[`WDTU_RCR_TO_BIT]) |->
    watchdog_reset || wake_request)
    else $error("flag set without time-out");
  flag_hold_a: assert property (
    reset_control_reg[`WDTU_RCR_TO_BIT] && !timeout_flag_clr |=>
    reset_control_reg[`WDTU_RCR_TO_BIT])
    else $error("flag dropped");
  swen_set_a: assert property (
    soft_enable_set && !watchdog_reset |=>
    reset_control_reg[`WDTU_RCR_SWEN_BIT])
    else $error("soft enable not set");
  ps_flag_a: assert property (
    power_save_instr && !sleep_flag_clr && !idle_flag_clr |=>
    reset_control_reg[`WDTU_RCR_SLEEP_BIT] ||
    reset_control_reg[`WDTU_RCR_IDLE_BIT])
    else $error("power-save flag not set");
endmodule : wdtu_props
bind wdtu_top wdtu_props u_props (.clk_sys, .rst_n, .watchdog_config_word,
  .power_save_instr, .soft_enable_set, .timeout_flag_clr, .sleep_flag_clr,
  .idle_flag_clr, .low_power_rc_osc_en, .watchdog_reset, .wake_request,
  .reset_control_reg);
`default_nettype wire

// ===== tb_watchdog_timeout_unit.sv
// Directed testbench for the watchdog time-out unit.
// Assumes wdtu_top, its package and header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_timeout_unit;
  import wdtu_pkg::*;
  // Stimulus and observed outputs
  logic clk_sys, rst_n, tick, psd, oen, wrst, wake;
  logic [7:0] cfg, rcr;
  logic [8:0] evv; // ci, csw, ps, exit, set, sclr, tclr, slclr, iclr
  int bad_count, checks;
  logic [7:0] n_rst, n_wake; // Pulses tallied since the last count check
  localparam logic [8:0] e_ci = 9'h100, e_csw = 9'h080, e_ps = 9'h040;
  localparam logic [8:0] e_exit = 9'h020, e_set = 9'h010, e_sclr = 9'h008;
  localparam logic [8:0] e_tclr = 9'h004, e_slclr = 9'h002, e_iclr = 9'h001;
  wdtu_top dut (.clk_sys, .rst_n, .watchdog_config_word(cfg), .osc_tick(tick),
    .watchdog_clear_instr(evv[8]), .power_save_instr(evv[6]),
    .power_save_idle(psd), .power_save_exit(evv[5]),
    .clock_switch_done(evv[7]), .soft_enable_set(evv[4]),
    .soft_enable_clr(evv[3]), .timeout_flag_clr(evv[2]),
    .sleep_flag_clr(evv[1]), .idle_flag_clr(evv[0]),
    .low_power_rc_osc_en(oen), .watchdog_reset(wrst), .wake_request(wake),
    .reset_control_reg(rcr));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Tally pulses at the falling edge, where outputs have settled
  always @(negedge clk_sys) begin
    if (wrst === 1'b1) n_rst++;
    if (wake === 1'b1) n_wake++;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Single status or enable bit
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // Oscillator ticks, one every other cycle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys) tick <= 1'b1;
      @(posedge clk_sys) tick <= 1'b0;
    end
  endtask : ticks
  // One-cycle pulse on the chosen core or software events; returns at
  // the falling edge so flags written by the pulse have settled
  task automatic ev(input logic [8:0] v);
    @(posedge clk_sys) evv <= v;
    @(posedge clk_sys) evv <= 9'h000;
    @(negedge clk_sys);
  endtask : ev
  // Pipeline is three cycles deep, so four cycles are ample
  task automatic cnt(input int r, input int w);
    repeat (4) @(negedge clk_sys);
    chk(n_rst, 8'(r));
    chk(n_wake, 8'(w));
    @(posedge clk_sys);
    n_rst = 8'h00;
    n_wake = 8'h00;
  endtask : cnt
  task automatic setcfg(input logic [7:0] v);
    @(posedge clk_sys) cfg <= v;
  endtask : setcfg
  task automatic results;
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // ****************************************
  // Scenarios
  // ****************************************
  // Fused on, divide by 32, ratio 1; software cannot stop it
  task automatic s_fuse;
    setcfg(8'hc0);
    ev(e_sclr);
    ticks(31);
    cnt(0, 0);
    ticks(1);
    cnt(1, 0);
    chk_bit(rcr[4], 1'b1);
    chk_bit(oen, 1'b1);
    ev(e_tclr);
    chk_bit(rcr[4], 1'b0);
  endtask : s_fuse
  // Divide by 128 with ratio 2 gives 256 ticks
  task automatic s_large;
    setcfg(8'hd1);
    ticks(255);
    cnt(0, 0);
    ticks(1);
    cnt(1, 0);
  endtask : s_large
  // Clear instruction and clock switch restart the count
  task automatic s_clears;
    logic [8:0] src [2];
    src = '{e_ci, e_csw};
    setcfg(8'hc0);
    foreach (src[i]) begin
      ticks(20);
      ev(src[i]);
      ticks(31);
      cnt(0, 0);
      ticks(1);
      cnt(1, 0);
    end
  endtask : s_clears
  // Sleep then idle: entry clears, time-out wakes, exit clears
  task automatic s_sleep;
    for (int idle = 0; idle < 2; idle++) begin
      @(posedge clk_sys) psd <= idle[0];
      ticks(20);
      ev(e_ps);
      chk_bit(rcr[3 - idle], 1'b1);
      ticks(31);
      cnt(0, 0);
      ticks(1);
      cnt(0, 1);
      ev(idle[0] ? e_iclr : e_slclr);
      chk_bit(rcr[3 - idle], 1'b0);
      ev(e_ps);
      ticks(20);
      ev(e_exit);
      ticks(31);
      cnt(0, 0);
      ticks(1);
      cnt(1, 0);
    end
  endtask : s_sleep
  // Software enable runs the watchdog, reset and clear stop it
  task automatic s_soft;
    setcfg(8'h40);
    ticks(40);
    cnt(0, 0);
    chk_bit(oen, 1'b0);
    ev(e_set);
    chk_bit(rcr[5], 1'b1);
    ticks(31);
    cnt(0, 0);
    ticks(1);
    cnt(1, 0);
    chk_bit(rcr[5], 1'b0);
    ev(e_set);
    ticks(20);
    ev(e_sclr);
    ticks(40);
    cnt(0, 0);
  endtask : s_soft
  // Mid-run device reset: soft enable drops and the count restarts, so
  // a leftover count of 20 would fire well before tick 32
  task automatic s_reset;
    setcfg(8'hc0);
    ev(e_set);
    chk_bit(rcr[5], 1'b1);
    ticks(20);
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk(rcr, 8'h00);
    ticks(31);
    cnt(0, 0);
    ticks(1);
    cnt(1, 0);
  endtask : s_reset
  // Windowed, ratio 4: window opens after three prescaler periods
  task automatic s_window;
    setcfg(8'h82);
    ticks(32);
    ev(e_ci);
    cnt(1, 0);
    ticks(96);
    ev(e_ci);
    cnt(0, 0);
    ticks(128);
    cnt(1, 0);
  endtask : s_window
  // ****************************************
  // Main sequence and hang guard
  // ****************************************
  initial begin
    {tick, psd, evv, cfg, rst_n} = '0;
    {bad_count, checks, n_rst, n_wake} = '0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk(rcr, 8'h00);
    s_fuse();
    s_large();
    s_clears();
    s_sleep();
    s_soft();
    s_reset();
    s_window();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    $display("Error at %0t: run hung", $time);
    results();
  end
endmodule : tb_watchdog_timeout_unit
`default_nettype wire
